// >>> testbench/enhanced_pwm_setup_and_modes_test.sv
`timescale 1ns/1ns
`include "epw_defines.svh"
module enhanced_pwm_setup_and_modes_test;
   import epw_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        fault_input_low, comp1, comp2, clk_fail, sleep_mode;
   logic        awready, wready, bvalid, arready, rvalid, int_a;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val;
   epw_resp_t   bresp, rresp;
   logic [3:0]  out, oe_n, pin;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;

   epw_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault_input_low(fault_input_low),
      .comp1_out(comp1), .comp2_out(comp2), .clock_fail(clk_fail), .sleep_mode(sleep_mode),
      .primary_clock_idle(1'b0), .internal_a(int_a), .out_a(out[0]), .out_a_oe_n(oe_n[0]),
      .out_b(out[1]), .out_b_oe_n(oe_n[1]), .out_c(out[2]), .out_c_oe_n(oe_n[2]), .out_d(out[3]),
      .out_d_oe_n(oe_n[3]));
   epw_bridge_model bridge (.drive(out), .drive_oe_n(oe_n), .gate(pin));

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // hang guard, far above the under two thousand cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask : idle

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input epw_resp_t er = `EPW_RESP_OKAY);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input epw_resp_t er = `EPW_RESP_OKAY);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      chk(32'(rresp), 32'(er));
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      rd(a, rd_val);
      chk(rd_val & {24'h0, m}, {24'h0, e});
   endtask : rc

   // counted on the far side of the pins, over whole periods so phase does not matter
   task automatic hi_count(input int idx, input int n, input int exp);
      int c;
      c = 0;
      repeat (n) begin
         @(negedge aclk);
         c += int'(pin[idx] === 1'b1);
      end
      chk(32'(c), 32'(exp));
   endtask : hi_count

   // pins go back to inputs around a polarity change so the bridge never sees it
   task automatic set_mode(input logic [7:0] v);
      wr(`EPW_OFS_PIN_DIRECTION, 8'h0F);
      wr(`EPW_OFS_OUTPUT_MODE, v);
      wr(`EPW_OFS_PIN_DIRECTION, 8'h00);
      idle(40);
   endtask : set_mode

   task automatic cause(input int k, input logic on);
      if (k == 0) comp1 <= on;
      else if (k == 1) comp2 <= on;
      else fault_input_low <= !on;
   endtask : cause

   task automatic reset_values();
      for (int i = 0; i < 10; i++) rc(8'(4 * i), 8'hFF, (i == 8) ? 8'h0F : 8'h00);
      chk(32'(oe_n), 32'hF);
      rd(8'h28, rd_val, `EPW_RESP_SLVERR);
      wr(8'h28, 8'h55, `EPW_RESP_SLVERR);
   endtask : reset_values

   // period of 16 clocks, duty 4, bring-up order kept by software
   task automatic setup_run();
      wr(`EPW_OFS_PERIOD_LIMIT, 8'h03);
      wr(`EPW_OFS_OUTPUT_MODE, 8'h0C);
      wr(`EPW_OFS_DUTY_LOW, 8'h01);
      wr(`EPW_OFS_SHUTDOWN, 8'h80);
      wr(`EPW_OFS_PERIPH_FLAGS, 8'h00);
      rc(`EPW_OFS_PERIPH_FLAGS, 8'h02, 8'h00);
      wr(`EPW_OFS_TIMER_CONTROL, 8'h04);
      idle(40);
      rc(`EPW_OFS_PERIPH_FLAGS, 8'h02, 8'h02);
      chk(32'(oe_n), 32'hF);
      wr(`EPW_OFS_PIN_DIRECTION, 8'h00);
      wr(`EPW_OFS_SHUTDOWN, 8'h00);
      idle(40);
      chk(32'(oe_n), 32'hE);
      hi_count(0, 32, 8);
   endtask : setup_run

   task automatic duty_polarity();
      wr(`EPW_OFS_DUTY_LOW, 8'h02);
      set_mode(8'h2C);
      hi_count(0, 32, 20);
      set_mode(8'h2E);
      hi_count(0, 32, 12);
      set_mode(8'h6D);
      hi_count(0, 32, 32);
      hi_count(3, 32, 12);
      hi_count(2, 32, 0);
      set_mode(8'hEC);
      hi_count(1, 32, 20);
      hi_count(2, 32, 32);
   endtask : duty_polarity

   task automatic deadband_shutdown();
      wr(`EPW_OFS_DEADBAND, 8'h05);
      set_mode(8'hAC);
      hi_count(0, 32, 10);
      hi_count(1, 32, 2);
      wr(`EPW_OFS_SHUTDOWN, 8'h14);
      comp1 <= 1'b1;
      idle(10);
      rc(`EPW_OFS_SHUTDOWN, 8'hFF, 8'h94);
      hi_count(0, 32, 32);
      hi_count(1, 32, 0);
      wr(`EPW_OFS_SHUTDOWN, 8'h14);
      rc(`EPW_OFS_SHUTDOWN, 8'hFF, 8'h94);
      comp1 <= 1'b0;
      idle(10);
      rc(`EPW_OFS_SHUTDOWN, 8'hFF, 8'h94);
      wr(`EPW_OFS_SHUTDOWN, 8'h14);
      rc(`EPW_OFS_SHUTDOWN, 8'hFF, 8'h14);
   endtask : deadband_shutdown

   // every source code against each cause alone, with restart on
   task automatic source_decode();
      wr(`EPW_OFS_DEADBAND, 8'h85);
      for (int s = 0; s < 8; s++) begin
         for (int k = 0; k < 3; k++) begin
            wr(`EPW_OFS_SHUTDOWN, 8'(s << 4));
            cause(k, 1'b1);
            idle(10);
            rc(`EPW_OFS_SHUTDOWN, 8'h80, {s[k], 7'h0});
            cause(k, 1'b0);
            idle(10);
            rc(`EPW_OFS_SHUTDOWN, 8'h80, 8'h00);
         end
      end
   endtask : source_decode

   task automatic sleep_clock_fail();
      logic [3:0] p;
      logic [7:0] v;
      sleep_mode <= 1'b1;
      idle(2);
      rd(`EPW_OFS_TIMER_COUNT, rd_val);
      v = rd_val[7:0];
      p = pin;
      idle(30);
      rc(`EPW_OFS_TIMER_COUNT, 8'hFF, v);
      chk(32'(pin), 32'(p));
      sleep_mode <= 1'b0;
      idle(40);
      hi_count(0, 32, 10);
      clk_fail <= 1'b1;
      idle(10);
      chk(32'(int_a), 32'h1);
      rc(`EPW_OFS_PERIPH_FLAGS, 8'h80, 8'h80);
      // a later reset must bring back the same defaults as power-on
      clk_fail <= 1'b0;
      aresetn  <= 1'b0;
      idle(2);
      aresetn  <= 1'b1;
      reset_values();
   endtask : sleep_clock_fail

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, comp1, comp2, clk_fail, sleep_mode} = '0;
      {awaddr, araddr, wdata} = '0;
      fault_input_low = 1'b1;
      aresetn = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      reset_values();
      setup_run();
      duty_polarity();
      deadband_shutdown();
      source_decode();
      sleep_clock_fail();
      close_out();
   end
endmodule : enhanced_pwm_setup_and_modes_test

// >>> testbench/epw_bridge_model.sv
`timescale 1ns/1ns
// switch drivers behind the pins: a released pin is pulled down, so its switch stays off
module epw_bridge_model (
   input  wire logic [3:0] drive,
   input  wire logic [3:0] drive_oe_n,
   output logic [3:0]      gate
);
   // pull-down wins while the pin is an input, never a stale driven level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gate[i] = drive_oe_n[i] ? 1'b0 : drive[i];
      end
   end
endmodule : epw_bridge_model

// >>> verilog/epw_defines.svh
`ifndef EPW_DEFINES_SVH
`define EPW_DEFINES_SVH

// register byte offsets on the bus
`define EPW_OFS_TIMER_COUNT    8'h00
`define EPW_OFS_TIMER_CONTROL  8'h04
`define EPW_OFS_PERIOD_LIMIT   8'h08
`define EPW_OFS_DUTY_LOW       8'h0C
`define EPW_OFS_DUTY_HIGH      8'h10
`define EPW_OFS_OUTPUT_MODE    8'h14
`define EPW_OFS_SHUTDOWN       8'h18
`define EPW_OFS_DEADBAND       8'h1C
`define EPW_OFS_PIN_DIRECTION  8'h20
`define EPW_OFS_PERIPH_FLAGS   8'h24

// output_mode_control fields
`define EPW_CFG_HI             7
`define EPW_CFG_LO             6
`define EPW_DLB_HI             5
`define EPW_DLB_LO             4
`define EPW_POL_AC_BIT         1
`define EPW_POL_BD_BIT         0
`define EPW_PWM_MODE_CODE      2'h3

// timer_control fields
`define EPW_PRESCALE_HI        1
`define EPW_PRESCALE_LO        0
`define EPW_TIMER_ON_BIT       2

// shutdown_control fields
`define EPW_SD_STATUS_BIT      7
`define EPW_SD_SRC_HI          6
`define EPW_SD_SRC_LO          4
`define EPW_SD_AC_HI           3
`define EPW_SD_AC_LO           2
`define EPW_SD_BD_HI           1
`define EPW_SD_BD_LO           0

// deadband_restart fields
`define EPW_RESTART_BIT        7
`define EPW_DB_HI              6
`define EPW_DB_LO              0

// periph flags fields
`define EPW_PERIOD_FLAG_BIT    1
`define EPW_OSC_FAIL_BIT       7
`define EPW_INTERNAL_CLK_BIT   0

// reset values
`define EPW_RST_REG            8'h00
`define EPW_RST_DIRECTION      4'hF

// timing: one instruction cycle per dead-band count
`define EPW_CLK_NS             100
`define EPW_TCY_NS             100
`define EPW_TCY_CYC            ((`EPW_TCY_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)

// bus answers
`define EPW_RESP_OKAY          2'h0
`define EPW_RESP_SLVERR        2'h2

`endif

// >>> verilog/epw_pkg.sv
package epw_pkg;
   // output pin configuration of the bridge
   typedef enum logic [1:0] {
      epw_single   = 2'h0,
      epw_full_fwd = 2'h1,
      epw_half     = 2'h2,
      epw_full_rev = 2'h3
   } epw_cfg_t;

   typedef logic [7:0] epw_byte_t;
   typedef logic [1:0] epw_resp_t;
endpackage : epw_pkg

// >>> verilog/epw_top.sv
`timescale 1ns/1ns
`include "epw_defines.svh"
// What this block does
// - reset makes pins inputs, registers default
// - polarity chosen per A/C and B/D pair
// - period flag sets when next period begins
// - period from limit, duty ten bits wide
// - half-bridge dead band from seven-bit field
// - deadband register bit seven enables restart
// - shutdown register picks sources and pair states
// - sleep freezes timer and unit state
// - pins keep their level through sleep
// - unit runs on whatever clock drives it
// - clock failure sets flag, internal clock mode
// - small package reads enhanced bits as zero
// - shutdown sets status; status writes ignored while cause persists
// - dead band counted in instruction cycles
// - restart clears status once cause is gone
// - source field decodes comparators and fault
module epw_top #(
   parameter bit SMALL_PKG = 1'b0
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output epw_pkg::epw_resp_t     s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output epw_pkg::epw_resp_t     s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              fault_input_low,
   input  wire logic              comp1_out,
   input  wire logic              comp2_out,
   input  wire logic              clock_fail,
   input  wire logic              sleep_mode,
   input  wire logic              primary_clock_idle,
   output logic                   internal_a,
   output logic                   out_a,
   output logic                   out_a_oe_n,
   output logic                   out_b,
   output logic                   out_b_oe_n,
   output logic                   out_c,
   output logic                   out_c_oe_n,
   output logic                   out_d,
   output logic                   out_d_oe_n
);
   import epw_pkg::*;

   // bus state
   logic [7:0]  aw_addr, next_aw_addr, w_data, next_w_data;
   logic        aw_full, next_aw_full, w_full, next_w_full, w_lane0, next_w_lane0;
   logic        bvalid, next_bvalid, rvalid, next_rvalid;
   epw_resp_t   bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   // registers and unit state
   epw_byte_t   timer_count, timer_control, period_limit, duty_low, duty_high;
   epw_byte_t   output_mode_control, shutdown_control, deadband_restart;
   epw_byte_t   next_timer_count, next_timer_control, next_period_limit, next_duty_low, next_duty_high;
   epw_byte_t   next_output_mode_control, next_shutdown_control, next_deadband_restart;
   logic [3:0]  pin_direction_bits, next_pin_direction_bits;
   logic        period_match_flag, next_period_match_flag, osc_fail_flag, next_osc_fail_flag;
   logic        on_internal, next_on_internal;
   logic [3:0]  presc_cnt, next_presc_cnt;
   logic [1:0]  sub_cnt, next_sub_cnt, duty_lat_lo, next_duty_lat_lo;
   logic        pwm_lvl, next_pwm_lvl, shut_hold, next_shut_hold;
   logic [6:0]  dead_cnt, next_dead_cnt;
   logic [3:0]  pin_val, next_pin_val, pin_oe_n, next_pin_oe_n;
   // pin synchronisers: fault, comp1, comp2, clock fail
   logic [3:0]  sync1, sync2, sync3, pin_flt, next_pin_flt;

   logic        do_write, ar_hs, tick, roll, cause, pwm_mode, dead_done;
   logic [3:0]  presc_max, active;
   logic [1:0]  pol;
   logic [7:0]  rd_byte;
   logic        rd_hit, wr_hit;
   epw_cfg_t    cfg;

   // bus handshakes; no slot takes a new request until the response is taken
   assign s_axi_awready = ~aw_full & ~bvalid;
   assign s_axi_wready  = ~w_full & ~bvalid;
   assign s_axi_arready = ~rvalid;
   assign {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp, s_axi_rdata} = {bvalid, bresp, rvalid, rresp, rdata};
   assign do_write      = aw_full & w_full;
   assign ar_hs         = s_axi_arvalid & ~rvalid;
   assign internal_a    = on_internal;
   assign {out_d, out_c, out_b, out_a}             = pin_val;
   assign {out_d_oe_n, out_c_oe_n, out_b_oe_n, out_a_oe_n} = pin_oe_n;

   // decode of the current configuration
   assign cfg       = epw_cfg_t'(output_mode_control[`EPW_CFG_HI:`EPW_CFG_LO]);
   assign pwm_mode  = output_mode_control[3:2] == `EPW_PWM_MODE_CODE;
   assign pol       = output_mode_control[`EPW_POL_AC_BIT:`EPW_POL_BD_BIT];
   assign presc_max = timer_control[`EPW_PRESCALE_HI] ? 4'hF : (timer_control[`EPW_PRESCALE_LO] ? 4'h3 : 4'h0);
   assign tick      = timer_control[`EPW_TIMER_ON_BIT] & ~sleep_mode & (presc_cnt == presc_max);
   assign roll      = tick & (sub_cnt == 2'h3) & (timer_count == period_limit);
   // fault is active low; the source field masks each cause
   assign cause     = (shutdown_control[`EPW_SD_SRC_LO] & pin_flt[1])
                    | (shutdown_control[`EPW_SD_SRC_LO+1] & pin_flt[2])
                    | (shutdown_control[`EPW_SD_SRC_HI] & ~pin_flt[0]);
   assign dead_done = {1'b0, dead_cnt} >= 8'(`EPW_TCY_CYC * deadband_restart[`EPW_DB_HI:`EPW_DB_LO]);

   // read mux; enhanced bits vanish on the small package
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      unique case (s_axi_araddr)
         `EPW_OFS_TIMER_COUNT:   rd_byte = timer_count;
         `EPW_OFS_TIMER_CONTROL: rd_byte = {1'b0, timer_control[6:0]};
         `EPW_OFS_PERIOD_LIMIT:  rd_byte = period_limit;
         `EPW_OFS_DUTY_LOW:      rd_byte = duty_low;
         `EPW_OFS_DUTY_HIGH:     rd_byte = duty_high;
         `EPW_OFS_OUTPUT_MODE:   rd_byte = output_mode_control;
         `EPW_OFS_SHUTDOWN:      rd_byte = shutdown_control;
         `EPW_OFS_DEADBAND:      rd_byte = deadband_restart;
         `EPW_OFS_PIN_DIRECTION: rd_byte = {4'h0, pin_direction_bits};
         `EPW_OFS_PERIPH_FLAGS:  rd_byte = {osc_fail_flag, 5'h00, period_match_flag, on_internal};
         default:                rd_hit  = 1'b0;
      endcase
   end

   // write decode
   always_comb begin
      unique case (aw_addr)
         `EPW_OFS_TIMER_COUNT, `EPW_OFS_TIMER_CONTROL, `EPW_OFS_PERIOD_LIMIT, `EPW_OFS_DUTY_LOW,
         `EPW_OFS_DUTY_HIGH, `EPW_OFS_OUTPUT_MODE, `EPW_OFS_SHUTDOWN, `EPW_OFS_DEADBAND,
         `EPW_OFS_PIN_DIRECTION, `EPW_OFS_PERIPH_FLAGS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // bus slave next state: address and data may arrive in either order
   always_comb begin
      {next_aw_addr, next_aw_full, next_w_data} = {aw_addr, aw_full, w_data};
      {next_w_full, next_w_lane0, next_bvalid, next_bresp} = {w_full, w_lane0, bvalid, bresp};
      {next_rvalid, next_rresp, next_rdata} = {rvalid, rresp, rdata};
      if (s_axi_awvalid & s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
         next_aw_full = 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         next_w_data  = s_axi_wdata[7:0];
         next_w_lane0 = s_axi_wstrb[0];
         next_w_full  = 1'b1;
      end
      if (do_write) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_hit ? `EPW_RESP_OKAY : `EPW_RESP_SLVERR;
      end else if (bvalid & s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (ar_hs) begin
         next_rvalid = 1'b1;
         next_rdata  = {24'h000000, rd_byte};
         next_rresp  = rd_hit ? `EPW_RESP_OKAY : `EPW_RESP_SLVERR;
      end else if (rvalid & s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // unit next state: software writes first, hardware events win over them
   always_comb begin
      logic wr;
      epw_byte_t wd;
      wr = do_write & w_lane0;
      wd = w_data;
      {next_timer_count, next_timer_control, next_period_limit} = {timer_count, timer_control, period_limit};
      {next_duty_low, next_duty_high, next_output_mode_control} = {duty_low, duty_high, output_mode_control};
      {next_shutdown_control, next_deadband_restart} = {shutdown_control, deadband_restart};
      {next_pin_direction_bits, next_period_match_flag} = {pin_direction_bits, period_match_flag};
      {next_osc_fail_flag, next_on_internal, next_presc_cnt} = {osc_fail_flag, on_internal, presc_cnt};
      {next_sub_cnt, next_duty_lat_lo, next_pwm_lvl, next_shut_hold} = {sub_cnt, duty_lat_lo, pwm_lvl, shut_hold};
      next_dead_cnt            = dead_cnt;
      next_pin_flt             = (sync2 == sync3) ? sync3 : pin_flt;
      if (wr) begin
         unique case (aw_addr)
            `EPW_OFS_TIMER_COUNT: begin
               next_timer_count = wd;
               next_presc_cnt   = 4'h0;
               next_sub_cnt     = 2'h0;
            end
            `EPW_OFS_TIMER_CONTROL: next_timer_control = {1'b0, wd[6:0]};
            `EPW_OFS_PERIOD_LIMIT:  next_period_limit  = wd;
            `EPW_OFS_DUTY_LOW:      next_duty_low      = wd;
            `EPW_OFS_OUTPUT_MODE:   next_output_mode_control = SMALL_PKG ? {2'h0, wd[5:0]} : wd;
            `EPW_OFS_SHUTDOWN: begin
               // status write is ignored while the cause persists
               next_shutdown_control = {cause ? shutdown_control[7] : wd[7],
                                        wd[6:2], SMALL_PKG ? 2'h0 : wd[1:0]};
            end
            `EPW_OFS_DEADBAND:      next_deadband_restart = {wd[7], SMALL_PKG ? 7'h00 : wd[6:0]};
            `EPW_OFS_PIN_DIRECTION: next_pin_direction_bits = wd[3:0];
            `EPW_OFS_PERIPH_FLAGS: begin
               next_period_match_flag = wd[`EPW_PERIOD_FLAG_BIT];
               next_osc_fail_flag     = wd[`EPW_OSC_FAIL_BIT];
            end
            default: ;
         endcase
      end
      // primary_clock_idle needs nothing here: the unit keeps its own clock
      if (pin_flt[3]) begin
         next_osc_fail_flag = 1'b1;
         next_on_internal   = 1'b1;
      end
      if (cause) next_shutdown_control[`EPW_SD_STATUS_BIT] = 1'b1;
      else if (deadband_restart[`EPW_RESTART_BIT]) next_shutdown_control[`EPW_SD_STATUS_BIT] = 1'b0;
      // timer runs only when on and awake; sleep holds every count
      if (timer_control[`EPW_TIMER_ON_BIT] & ~sleep_mode) begin
         next_presc_cnt = tick ? 4'h0 : presc_cnt + 4'h1;
         if (tick) begin
            next_sub_cnt = sub_cnt + 2'h1;
            if (sub_cnt == 2'h3) next_timer_count = timer_count + 8'h01;
         end
      end
      if (roll) begin
         next_timer_count       = 8'h00;
         next_period_match_flag = 1'b1;
         next_duty_high         = duty_low;
         next_duty_lat_lo       = output_mode_control[`EPW_DLB_HI:`EPW_DLB_LO];
         next_pwm_lvl           = {duty_low, output_mode_control[`EPW_DLB_HI:`EPW_DLB_LO]} != 10'h000;
         next_shut_hold         = shutdown_control[`EPW_SD_STATUS_BIT];
      end else if (tick & ({next_timer_count, next_sub_cnt} == {duty_high, duty_lat_lo})) begin
         next_pwm_lvl = 1'b0; // low on the tick that reaches duty, so high time equals duty
      end
      if (sleep_mode) next_dead_cnt = dead_cnt;
      else if (next_pwm_lvl != pwm_lvl) next_dead_cnt = 7'h00;
      else if (~dead_done) next_dead_cnt = dead_cnt + 7'h01;
   end

   // active levels per pin before polarity, then polarity and shutdown
   always_comb begin
      active = 4'h0;
      unique case (cfg)
         epw_single:   active = {3'h0, pwm_lvl};
         epw_full_fwd: active = {pwm_lvl, 2'h0, 1'b1};
         epw_half:     active = {2'h0, ~pwm_lvl & dead_done, pwm_lvl & dead_done};
         epw_full_rev: active = {1'b0, 1'b1, pwm_lvl, 1'b0};
      endcase
      next_pin_val  = active ^ {pol[0], pol[1], pol[0], pol[1]};
      next_pin_oe_n = pin_direction_bits | {4{~pwm_mode}};
      unique case (cfg)
         epw_single: next_pin_oe_n = next_pin_oe_n | 4'hE;
         epw_half:   next_pin_oe_n = next_pin_oe_n | 4'hC;
         default:    ;
      endcase
      if (shutdown_control[`EPW_SD_STATUS_BIT] | shut_hold) begin
         next_pin_val  = {shutdown_control[`EPW_SD_BD_LO], shutdown_control[`EPW_SD_AC_LO],
                          shutdown_control[`EPW_SD_BD_LO], shutdown_control[`EPW_SD_AC_LO]};
         next_pin_oe_n = next_pin_oe_n | {shutdown_control[`EPW_SD_BD_HI], shutdown_control[`EPW_SD_AC_HI],
                                          shutdown_control[`EPW_SD_BD_HI], shutdown_control[`EPW_SD_AC_HI]};
      end
      if (sleep_mode) begin
         next_pin_val  = pin_val;
         next_pin_oe_n = pin_oe_n;
      end
   end

   // one clocked block for everything, inputs through a three-deep synchroniser; reset returns the compatible state
   always_ff @(posedge aclk) begin
      sync1 <= {clock_fail, comp2_out, comp1_out, fault_input_low};
      sync2 <= sync1;
      sync3 <= sync2;
      if (!aresetn) begin
         {aw_addr, w_data, aw_full, w_full, w_lane0, bvalid, rvalid} <= '0;
         bresp <= `EPW_RESP_OKAY;
         rresp <= `EPW_RESP_OKAY;
         rdata <= 32'h00000000;
         {timer_count, timer_control, period_limit, duty_low} <= {4{`EPW_RST_REG}};
         {duty_high, output_mode_control, shutdown_control, deadband_restart} <= {4{`EPW_RST_REG}};
         pin_direction_bits <= `EPW_RST_DIRECTION;
         {period_match_flag, osc_fail_flag, on_internal, pwm_lvl, shut_hold} <= '0;
         {presc_cnt, sub_cnt, duty_lat_lo, dead_cnt} <= '0;
         pin_val  <= 4'h0;
         pin_oe_n <= 4'hF;
         pin_flt  <= 4'h1;
      end else begin
         {aw_addr, w_data, aw_full, w_full, w_lane0} <= {next_aw_addr, next_w_data, next_aw_full, next_w_full,
                                                         next_w_lane0};
         {bvalid, bresp, rvalid, rresp, rdata} <= {next_bvalid, next_bresp, next_rvalid, next_rresp, next_rdata};
         timer_count         <= next_timer_count;
         timer_control       <= next_timer_control;
         period_limit        <= next_period_limit;
         duty_low            <= next_duty_low;
         duty_high           <= next_duty_high;
         output_mode_control <= next_output_mode_control;
         shutdown_control    <= next_shutdown_control;
         deadband_restart    <= next_deadband_restart;
         pin_direction_bits  <= next_pin_direction_bits;
         {period_match_flag, osc_fail_flag, on_internal} <= {next_period_match_flag, next_osc_fail_flag,
                                                             next_on_internal};
         {presc_cnt, sub_cnt, duty_lat_lo, dead_cnt} <= {next_presc_cnt, next_sub_cnt, next_duty_lat_lo,
                                                         next_dead_cnt};
         {pwm_lvl, shut_hold, pin_val, pin_oe_n, pin_flt} <= {next_pwm_lvl, next_shut_hold, next_pin_val,
                                                              next_pin_oe_n, next_pin_flt};
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_inputs: assert property ($rose(aresetn) |-> pin_oe_n == 4'hF)
      else $error("pins not inputs after reset");
   a_flag_on_roll: assert property (roll |=> period_match_flag && timer_count == 8'h00)
      else $error("period flag missing at new period");
   a_sleep_freeze: assert property (sleep_mode && $past(sleep_mode) |-> $stable(timer_count) && $stable(pin_val))
      else $error("state moved during sleep");
   a_shut_sets: assert property (cause |=> shutdown_control[7])
      else $error("shutdown status not set");
   a_restart_clr: assert property (!cause && deadband_restart[7] && !(do_write && aw_addr == 8'h18)
                                   |=> !shutdown_control[7])
      else $error("auto restart did not clear status");
   a_hold_no_rst: assert property (shutdown_control[7] && !deadband_restart[7] && !do_write |=> shutdown_control[7])
      else $error("status cleared without software");
   a_osc_fail: assert property (pin_flt[3] |=> osc_fail_flag && on_internal)
      else $error("clock failure not flagged");
   a_polarity_ac: assert property (pwm_mode && cfg == epw_single && !shutdown_control[7] && !shut_hold
                                   && !sleep_mode |=> out_a == ($past(pwm_lvl) ^ $past(pol[1])))
      else $error("A output level wrong");
   a_small_zero: assert property (SMALL_PKG |-> deadband_restart[6:0] == 7'h00 && output_mode_control[7:6] == 2'h0)
      else $error("enhanced bits not zero");
endmodule : epw_top
